// *** logic/reset_seq_pkg.sv ***
// Constants, field positions and types of the reset sequencer.
package reset_seq_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_FREQ_HZ = 125000000;
  localparam int CLK_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int CLK_PER_US = CLK_FREQ_HZ / 1000000;
  localparam int POWERUP_DELAY_PERIOD_MS = 72;
  localparam int POWERUP_DELAY_CYCLES = POWERUP_DELAY_PERIOD_MS * CLK_PER_MS;
  localparam int SUPPLY_DROP_MIN_DURATION_US = 100;
  localparam int SUPPLY_DROP_MIN_CYCLES =
    SUPPLY_DROP_MIN_DURATION_US * CLK_PER_US;
  localparam int OSC_STARTUP_EDGES = 1024;
  localparam int DUMMY_CYCLES = 2;
  localparam logic [12:0] IRQ_VECTOR_ADDR = 13'h0004;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [31:0] CONFIG_OFFSET = 32'h00000000;
  localparam logic [31:0] STATUS_OFFSET = 32'h00000004;
  localparam int CFG_DROP_EN_BIT = 0;
  localparam int CFG_POWERUP_DELAY_TIMER_EN_BIT = 1;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_GIE_BIT = 4;
  localparam logic [4:0] CONFIG_RESET = 5'h07;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_CORE_RESET_BIT = 8;
  localparam int STS_POR_CAUSE_BIT = 9;
  localparam int STS_DROP_CAUSE_BIT = 10;
  localparam int STS_MASTER_CLEAR_PIN_CAUSE_BIT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    MODE_LOW_POWER_CRYSTAL = 2'h0,
    MODE_STANDARD_CRYSTAL = 2'h1,
    MODE_HIGH_SPEED_CRYSTAL = 2'h2,
    MODE_RC = 2'h3
  } osc_mode_e;

  typedef enum logic [7:0] {
    ST_POWERUP_DELAY_TIMER = 8'h01,
    ST_OST = 8'h02,
    ST_HELD = 8'h04,
    ST_DROP = 8'h08,
    ST_RUN = 8'h10,
    ST_SLEEP = 8'h20,
    ST_WAKE_OST = 8'h40,
    ST_DUMMY = 8'h80
  } seq_state_e;

endpackage

// *** logic/step_counter.sv ***
// Saturating step counter that flags when a set number of steps is reached.
`timescale 1ns/1ps
`default_nettype none
module step_counter #(
  parameter int LIMIT = 1024
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic clear_in,
  input wire logic step_in,
  output logic expired_out
);

  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIMIT_W = W'(LIMIT);

  logic [W-1:0] cnt_ff;

  if (LIMIT < 1) begin : g_chk
    $error("step_counter LIMIT must be at least one");
  end

  assign expired_out = (cnt_ff == LIMIT_W);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= '0;
    end else if (ce_in) begin
      if (clear_in) begin
        cnt_ff <= '0;
      end else if (step_in && !expired_out) begin
        cnt_ff <= cnt_ff + W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/osc_edge_detect.sv ***
// Rising-edge detector for the sampled oscillator input pin.
`timescale 1ns/1ps
`default_nettype none
module osc_edge_detect (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic osc_in,
  output logic rise_out
);

  logic prev_ff;

  assign rise_out = osc_in && !prev_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_ff <= 1'b1;
    end else if (ce_in) begin
      prev_ff <= osc_in;
    end
  end

endmodule
`default_nettype wire

// *** logic/reset_timeout_sequencer.sv ***
// Reset release sequencer with power-up timer, start-up count and drop filter.
//
// Notes on behaviour
// - The start-up count waits 1024 edges, after the timer if it is on.
// - Only crystal modes run the start-up count, after power-on or wake-up.
// - One enable bit switches the whole supply drop reset on or off.
// - Supply-low held past the minimum duration resets the device.
// - Drop reset holds until supply-low clears.
// - After drop recovery the power-up timer holds reset for its period.
// - Supply-low during that timer restarts the drop sequence and the timer.
// - With supply drop reset enabled the power-up timer is always on.
// - Power-on runs the timer if enabled, then the start-up count in crystal modes.
// - Reset ends with the start-up count if no other source is active; in RC mode and after drop recovery it ends after the power-up timer.
// - Timers run while master clear is low; the core starts when it rises.
// - Wake-up with interrupts on branches to 0004h after the dummy cycles.
// - The fixed power-up delay starts on power-on or drop recovery only.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer #(
  parameter int POWERUP_DELAY_TIMER_CYCLES = reset_seq_pkg::POWERUP_DELAY_CYCLES,
  parameter int DROP_CYCLES = reset_seq_pkg::SUPPLY_DROP_MIN_CYCLES,
  parameter int OST_EDGES = reset_seq_pkg::OSC_STARTUP_EDGES,
  parameter int DUMMY_COUNT = reset_seq_pkg::DUMMY_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  input wire logic POWER_ON_IN,
  input wire logic SUPPLY_LOW_IN,
  input wire logic MASTER_CLEAR_B_IN,
  input wire logic OSCILLATOR_INPUT_PIN_IN,
  input wire logic SLEEP_IN,
  input wire logic WAKE_IN,
  output logic CORE_RESET_OUT,
  output logic CORE_HALT_OUT,
  output logic VECTOR_VALID_OUT,
  output logic [12:0] VECTOR_ADDR_OUT,
  output logic RESUME_OUT,
  input wire logic [31:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [31:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN
);

  // ********************************************************************
  // Parameter checks
  // ********************************************************************
  if (POWERUP_DELAY_TIMER_CYCLES < 1 || DROP_CYCLES < 1 || OST_EDGES < 1) begin : g_chk_t
    $error("timer counts must be at least one");
  end
  if (DUMMY_COUNT < 2) begin : g_chk_d
    $error("DUMMY_COUNT must be at least two");
  end

  // ********************************************************************
  // Declarations
  // ********************************************************************
  reset_seq_pkg::seq_state_e state_ff;
  reset_seq_pkg::seq_state_e nxt_state;
  logic por_seq_ff;
  logic nxt_por_seq;
  logic [4:0] config_ff;
  logic drop_en;
  logic powerup_delay_timer_en_bit;
  logic global_interrupt_enable;
  reset_seq_pkg::osc_mode_e osc_mode;
  logic crystal_mode;
  logic powerup_delay_timer_on;
  logic supply_low;
  logic drop_trip;
  logic powerup_delay_timer_done;
  logic ost_done;
  logic dummy_done;
  logic osc_rise;
  logic master_clear_pin_high;
  logic core_reset_ff;
  logic core_halt_ff;
  logic vector_valid_ff;
  logic [12:0] vector_addr_ff;
  logic resume_ff;
  logic por_cause_ff;
  logic drop_cause_ff;
  logic master_clear_pin_cause_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  logic wr_config;
  logic wr_status;
  logic [31:0] status_word;

  // ********************************************************************
  // Configuration decode
  // ********************************************************************
  assign drop_en = config_ff[reset_seq_pkg::CFG_DROP_EN_BIT];
  assign powerup_delay_timer_en_bit = config_ff[reset_seq_pkg::CFG_POWERUP_DELAY_TIMER_EN_BIT];
  assign global_interrupt_enable = config_ff[reset_seq_pkg::CFG_GIE_BIT];
  assign osc_mode = reset_seq_pkg::osc_mode_e'(
    config_ff[reset_seq_pkg::CFG_MODE_LSB +: 2]);
  assign crystal_mode = (osc_mode != reset_seq_pkg::MODE_RC);
  assign powerup_delay_timer_on = powerup_delay_timer_en_bit || drop_en;
  assign supply_low = SUPPLY_LOW_IN && drop_en;
  assign master_clear_pin_high = MASTER_CLEAR_B_IN;

  // ********************************************************************
  // Timers
  // ********************************************************************
  // The power-up timer counts core clocks as its internal time base.
  step_counter #(
    .LIMIT(POWERUP_DELAY_TIMER_CYCLES)
  ) u_powerup_delay_timer (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .clear_in(state_ff != reset_seq_pkg::ST_POWERUP_DELAY_TIMER || POWER_ON_IN),
    .step_in(1'b1),
    .expired_out(powerup_delay_timer_done)
  );

  osc_edge_detect u_osc_edge (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .osc_in(OSCILLATOR_INPUT_PIN_IN),
    .rise_out(osc_rise)
  );

  step_counter #(
    .LIMIT(OST_EDGES)
  ) u_oscillator_startup_counter (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .clear_in((state_ff != reset_seq_pkg::ST_OST &&
               state_ff != reset_seq_pkg::ST_WAKE_OST) || POWER_ON_IN),
    .step_in(osc_rise),
    .expired_out(ost_done)
  );

  // Short supply-low pulses clear the filter before it expires.
  step_counter #(
    .LIMIT(DROP_CYCLES)
  ) u_supply_drop_filter (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .clear_in(!supply_low),
    .step_in(1'b1),
    .expired_out(drop_trip)
  );

  step_counter #(
    .LIMIT(DUMMY_COUNT - 1)
  ) u_dummy_counter (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .clear_in(state_ff != reset_seq_pkg::ST_DUMMY),
    .step_in(1'b1),
    .expired_out(dummy_done)
  );

  // ********************************************************************
  // Sequence control
  // ********************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_por_seq = por_seq_ff;
    if (POWER_ON_IN) begin
      nxt_state = reset_seq_pkg::ST_POWERUP_DELAY_TIMER;
      nxt_por_seq = 1'b1;
    end else if (drop_trip && state_ff != reset_seq_pkg::ST_DROP) begin
      nxt_state = reset_seq_pkg::ST_DROP;
    end else begin
      case (state_ff)
        reset_seq_pkg::ST_DROP: begin
          if (!supply_low) begin
            nxt_state = reset_seq_pkg::ST_POWERUP_DELAY_TIMER;
            nxt_por_seq = 1'b0;
          end
        end
        reset_seq_pkg::ST_POWERUP_DELAY_TIMER: begin
          if (!por_seq_ff && supply_low) begin
            nxt_state = reset_seq_pkg::ST_DROP;
          end else if (powerup_delay_timer_done || !powerup_delay_timer_on) begin
            if (por_seq_ff && crystal_mode) begin
              nxt_state = reset_seq_pkg::ST_OST;
            end else if (master_clear_pin_high) begin
              nxt_state = reset_seq_pkg::ST_RUN;
            end else begin
              nxt_state = reset_seq_pkg::ST_HELD;
            end
          end
        end
        reset_seq_pkg::ST_OST: begin
          if (ost_done) begin
            if (master_clear_pin_high) begin
              nxt_state = reset_seq_pkg::ST_RUN;
            end else begin
              nxt_state = reset_seq_pkg::ST_HELD;
            end
          end
        end
        reset_seq_pkg::ST_HELD: begin
          if (master_clear_pin_high) begin
            nxt_state = reset_seq_pkg::ST_RUN;
          end
        end
        reset_seq_pkg::ST_RUN: begin
          if (!master_clear_pin_high) begin
            nxt_state = reset_seq_pkg::ST_HELD;
          end else if (SLEEP_IN) begin
            nxt_state = reset_seq_pkg::ST_SLEEP;
          end
        end
        reset_seq_pkg::ST_SLEEP: begin
          if (!master_clear_pin_high) begin
            nxt_state = reset_seq_pkg::ST_HELD;
          end else if (WAKE_IN && crystal_mode) begin
            nxt_state = reset_seq_pkg::ST_WAKE_OST;
          end else if (WAKE_IN) begin
            nxt_state = reset_seq_pkg::ST_DUMMY;
          end
        end
        reset_seq_pkg::ST_WAKE_OST: begin
          if (!master_clear_pin_high) begin
            nxt_state = reset_seq_pkg::ST_HELD;
          end else if (ost_done) begin
            nxt_state = reset_seq_pkg::ST_DUMMY;
          end
        end
        reset_seq_pkg::ST_DUMMY: begin
          if (!master_clear_pin_high) begin
            nxt_state = reset_seq_pkg::ST_HELD;
          end else if (dummy_done) begin
            nxt_state = reset_seq_pkg::ST_RUN;
          end
        end
        default: begin
          nxt_state = reset_seq_pkg::ST_POWERUP_DELAY_TIMER;
          nxt_por_seq = 1'b1;
        end
      endcase
    end
  end

  // Leaving reset by the asynchronous reset counts as a power-on.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_ff <= reset_seq_pkg::ST_POWERUP_DELAY_TIMER;
      por_seq_ff <= 1'b1;
    end else if (CE_IN) begin
      state_ff <= nxt_state;
      por_seq_ff <= nxt_por_seq;
    end
  end

  // ********************************************************************
  // Core controls
  // ********************************************************************
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      core_reset_ff <= 1'b1;
      core_halt_ff <= 1'b0;
    end else if (CE_IN) begin
      core_reset_ff <= (nxt_state == reset_seq_pkg::ST_POWERUP_DELAY_TIMER) ||
                       (nxt_state == reset_seq_pkg::ST_OST) ||
                       (nxt_state == reset_seq_pkg::ST_HELD) ||
                       (nxt_state == reset_seq_pkg::ST_DROP);
      core_halt_ff <= (nxt_state == reset_seq_pkg::ST_SLEEP) ||
                      (nxt_state == reset_seq_pkg::ST_WAKE_OST) ||
                      (nxt_state == reset_seq_pkg::ST_DUMMY);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      vector_valid_ff <= 1'b0;
      vector_addr_ff <= 13'h0000;
      resume_ff <= 1'b0;
    end else if (CE_IN) begin
      vector_valid_ff <= 1'b0;
      resume_ff <= 1'b0;
      if (state_ff == reset_seq_pkg::ST_DUMMY &&
          nxt_state == reset_seq_pkg::ST_RUN) begin
        if (global_interrupt_enable) begin
          vector_valid_ff <= 1'b1;
          vector_addr_ff <= reset_seq_pkg::IRQ_VECTOR_ADDR;
        end else begin
          resume_ff <= 1'b1;
        end
      end
    end
  end

  assign CORE_RESET_OUT = core_reset_ff;
  assign CORE_HALT_OUT = core_halt_ff;
  assign VECTOR_VALID_OUT = vector_valid_ff;
  assign VECTOR_ADDR_OUT = vector_addr_ff;
  assign RESUME_OUT = resume_ff;

  // ********************************************************************
  // Reset cause flags
  // ********************************************************************
  // A new cause in the cycle of a clear keeps its flag set.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      por_cause_ff <= 1'b1;
      drop_cause_ff <= 1'b0;
      master_clear_pin_cause_ff <= 1'b0;
    end else if (CE_IN) begin
      if (POWER_ON_IN) begin
        por_cause_ff <= 1'b1;
      end else if (wr_status &&
                   wdata_ff[reset_seq_pkg::STS_POR_CAUSE_BIT]) begin
        por_cause_ff <= 1'b0;
      end
      if (drop_trip) begin
        drop_cause_ff <= 1'b1;
      end else if (wr_status &&
                   wdata_ff[reset_seq_pkg::STS_DROP_CAUSE_BIT]) begin
        drop_cause_ff <= 1'b0;
      end
      if (!master_clear_pin_high) begin
        master_clear_pin_cause_ff <= 1'b1;
      end else if (wr_status &&
                   wdata_ff[reset_seq_pkg::STS_MASTER_CLEAR_PIN_CAUSE_BIT]) begin
        master_clear_pin_cause_ff <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // AXI4-Lite slave
  // ********************************************************************
  assign AXI_AWREADY_OUT = !aw_held_ff && !bvalid_ff;
  assign AXI_WREADY_OUT = !w_held_ff && !bvalid_ff;
  assign AXI_ARREADY_OUT = !rvalid_ff;
  assign aw_take = AXI_AWVALID_IN && AXI_AWREADY_OUT;
  assign w_take = AXI_WVALID_IN && AXI_WREADY_OUT;
  assign ar_take = AXI_ARVALID_IN && AXI_ARREADY_OUT;
  assign wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_config = wr_do && (awaddr_ff == reset_seq_pkg::CONFIG_OFFSET);
  assign wr_status = wr_do && (awaddr_ff == reset_seq_pkg::STATUS_OFFSET) &&
                     wstrb_ff[1];

  always_comb begin
    status_word = 32'h00000000;
    status_word[reset_seq_pkg::STS_STATE_LSB +: 8] = state_ff;
    status_word[reset_seq_pkg::STS_CORE_RESET_BIT] = core_reset_ff;
    status_word[reset_seq_pkg::STS_POR_CAUSE_BIT] = por_cause_ff;
    status_word[reset_seq_pkg::STS_DROP_CAUSE_BIT] = drop_cause_ff;
    status_word[reset_seq_pkg::STS_MASTER_CLEAR_PIN_CAUSE_BIT] = master_clear_pin_cause_ff;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 32'h00000000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= reset_seq_pkg::RESP_OKAY;
    end else if (CE_IN) begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {AXI_AWADDR_IN[31:2], 2'h0};
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff <= AXI_WDATA_IN;
        wstrb_ff <= AXI_WSTRB_IN;
      end
      if (wr_do) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        if (awaddr_ff == reset_seq_pkg::CONFIG_OFFSET ||
            awaddr_ff == reset_seq_pkg::STATUS_OFFSET) begin
          bresp_ff <= reset_seq_pkg::RESP_OKAY;
        end else begin
          bresp_ff <= reset_seq_pkg::RESP_SLVERR;
        end
      end else if (bvalid_ff && AXI_BREADY_IN) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      config_ff <= reset_seq_pkg::CONFIG_RESET;
    end else if (CE_IN && wr_config && wstrb_ff[0]) begin
      config_ff <= wdata_ff[4:0];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= reset_seq_pkg::RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (CE_IN) begin
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        if ({AXI_ARADDR_IN[31:2], 2'h0} == reset_seq_pkg::CONFIG_OFFSET) begin
          rdata_ff <= {27'h0000000, config_ff};
          rresp_ff <= reset_seq_pkg::RESP_OKAY;
        end else if ({AXI_ARADDR_IN[31:2], 2'h0} ==
                     reset_seq_pkg::STATUS_OFFSET) begin
          rdata_ff <= status_word;
          rresp_ff <= reset_seq_pkg::RESP_OKAY;
        end else begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= reset_seq_pkg::RESP_SLVERR;
        end
      end else if (rvalid_ff && AXI_RREADY_IN) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign AXI_BVALID_OUT = bvalid_ff;
  assign AXI_BRESP_OUT = bresp_ff;
  assign AXI_RVALID_OUT = rvalid_ff;
  assign AXI_RRESP_OUT = rresp_ff;
  assign AXI_RDATA_OUT = rdata_ff;

endmodule
`default_nettype wire

// *** bench/reset_timeout_sequencer_assertions.sv ***
// Port assertions for the reset release sequencer.
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer_assertions (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  input wire logic POWER_ON_IN,
  input wire logic MASTER_CLEAR_B_IN,
  input wire logic CORE_RESET_OUT,
  input wire logic CORE_HALT_OUT,
  input wire logic VECTOR_VALID_OUT,
  input wire logic [12:0] VECTOR_ADDR_OUT,
  input wire logic RESUME_OUT,
  input wire logic AXI_AWVALID_IN,
  input wire logic AXI_AWREADY_OUT,
  input wire logic AXI_WVALID_IN,
  input wire logic AXI_WREADY_OUT,
  input wire logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic AXI_ARVALID_IN,
  input wire logic AXI_ARREADY_OUT,
  input wire logic AXI_RVALID_OUT
);
  // ****
  // Checks
  // ****
  default clocking dc @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  sequence s_write_taken;
    CE_IN && AXI_AWVALID_IN && AXI_AWREADY_OUT &&
      AXI_WVALID_IN && AXI_WREADY_OUT;
  endsequence
  sequence s_halt_ends;
    $fell(CORE_HALT_OUT) ##1
      VECTOR_ADDR_OUT == reset_seq_pkg::IRQ_VECTOR_ADDR;
  endsequence
  a_master_clear_pin_holds: assert property (
    CE_IN && !MASTER_CLEAR_B_IN |=> CORE_RESET_OUT) else $error("master_clear_pin");
  a_power_on_holds: assert property (
    CE_IN && POWER_ON_IN |=> CORE_RESET_OUT) else $error("power on");
  a_release_cause: assert property (
    $fell(CORE_RESET_OUT) |-> $past(MASTER_CLEAR_B_IN) &&
      !$past(POWER_ON_IN)) else $error("release cause");
  a_vector_branch: assert property (
    VECTOR_VALID_OUT |-> s_halt_ends) else $error("vector");
  a_resume_wake: assert property (
    RESUME_OUT |-> $fell(CORE_HALT_OUT) && !VECTOR_VALID_OUT)
    else $error("resume");
  a_pulse_single: assert property (
    VECTOR_VALID_OUT || RESUME_OUT |=> !(VECTOR_VALID_OUT || RESUME_OUT))
    else $error("pulse width");
  a_write_answer: assert property (
    s_write_taken |-> ##2 AXI_BVALID_OUT) else $error("bvalid late");
  a_read_answer: assert property (
    CE_IN && AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT)
    else $error("rvalid late");
  a_bresp_stands: assert property (
    AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT) else $error("bvalid");
  a_read_refused: assert property (
    AXI_RVALID_OUT |-> !AXI_ARREADY_OUT) else $error("arready");
endmodule
`default_nettype wire

// *** bench/reset_timeout_sequencer_test.sv ***
// Self-checking bench for the reset release sequencer.
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer_test;
  localparam int PW = 20;
  localparam int DR = 8;
  localparam int OE = 4;
  localparam logic [31:0] CFG = reset_seq_pkg::CONFIG_OFFSET;
  localparam logic [31:0] STS = reset_seq_pkg::STATUS_OFFSET;
  logic clk, rst_b, ce, power_on, supply_low, master_clear_pin_b, osc, osc_run;
  logic sleep, wake, core_reset, core_halt, vec_valid, resume;
  logic [12:0] vec_addr;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_fail, n_tests, cyc, n;

  reset_timeout_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(PW), .DROP_CYCLES(DR),
    .OST_EDGES(OE)) uut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .POWER_ON_IN(power_on),
    .SUPPLY_LOW_IN(supply_low), .MASTER_CLEAR_B_IN(master_clear_pin_b),
    .OSCILLATOR_INPUT_PIN_IN(osc), .SLEEP_IN(sleep), .WAKE_IN(wake),
    .CORE_RESET_OUT(core_reset), .CORE_HALT_OUT(core_halt),
    .VECTOR_VALID_OUT(vec_valid), .VECTOR_ADDR_OUT(vec_addr),
    .RESUME_OUT(resume), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
    .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
    .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready));

  // ****
  // Tasks
  // ****
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic pon;
    power_on <= 1'b1;
    tick(1);
    power_on <= 1'b0;
  endtask

  // Outputs are looked at on the falling edge, where they have settled.
  task automatic peek(input logic [1:0] e);
    @(negedge clk);
    chk("reset_halt", {30'h0, e}, {30'h0, core_reset, core_halt});
    @(posedge clk);
  endtask

  task automatic run_to(input int lim, output int k);
    k = 0;
    @(negedge clk);
    while (core_reset !== 1'b0 && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("released", 32'h0, {31'h0, core_reset});
    @(posedge clk);
  endtask

  // One bus transfer; for a read d is the expected data.
  task automatic axi(input logic wr, input logic [31:0] a, d,
    input logic [1:0] er);
    logic ta, tw, tr;
    logic [1:0] rs;
    logic [31:0] rd;
    int k;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    k = 0;
    tr = 1'b0;
    while (!tr && k < 40) begin
      @(negedge clk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tr = wr ? bvalid : rvalid;
      rs = wr ? bresp : rresp;
      rd = rdata;
      @(posedge clk);
      awvalid <= awvalid && !ta;
      arvalid <= arvalid && !ta;
      wvalid <= wvalid && !tw;
      k++;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    tick(1);
    chk("resp", {29'h0, 1'b1, er}, {29'h0, tr, rs});
    if (!wr)
      chk("rdata", d, rd);
  endtask

  task automatic cfg(input logic [31:0] d);
    axi(1'b1, CFG, d, reset_seq_pkg::RESP_OKAY);
  endtask

  // ****
  // Stimulus
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (osc_run)
      osc <= ~osc;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    {rst_b, power_on, supply_low, osc, osc_run, sleep, wake} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    ce = 1'b1;
    master_clear_pin_b = 1'b1;
    wstrb = 4'hf;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    tick(20);
    rst_b <= 1'b1;
    axi(1'b0, reset_seq_pkg::STATUS_OFFSET, 32'h301, 2'h0);
    axi(1'b0, CFG, 32'h7, 2'h0);
    axi(1'b0, 32'h8, 32'h0, reset_seq_pkg::RESP_SLVERR);
    for (int m = 0; m < 4; m++) begin
      cfg(32'h3 | (32'(m) << 2));
      osc_run <= 1'b0;
      pon();
      tick(PW + 8);
      peek({m != 3, 1'b0});
      osc_run <= 1'b1;
      run_to(2 * OE + 8, n);
      chk("ost_span", 32'h1, {31'h0, m == 3 ? n < 2 : n > OE});
    end
    cfg(32'h7);
    master_clear_pin_b <= 1'b0;
    pon();
    tick(PW + 2 * OE + 20);
    peek(2'h2);
    master_clear_pin_b <= 1'b1;
    run_to(3, n);
    cfg(32'hd);
    supply_low <= 1'b1;
    tick(DR - 1);
    supply_low <= 1'b0;
    tick(3);
    peek(2'h0);
    supply_low <= 1'b1;
    tick(DR + 30);
    peek(2'h2);
    supply_low <= 1'b0;
    tick(PW - 4);
    peek(2'h2);
    supply_low <= 1'b1;
    tick(2);
    supply_low <= 1'b0;
    tick(PW - 4);
    peek(2'h2);
    run_to(12, n);
    axi(1'b0, STS, 32'he10, 2'h0);
    axi(1'b1, STS, 32'he00, 2'h0);
    axi(1'b0, STS, 32'h10, 2'h0);
    cfg(32'hc);
    supply_low <= 1'b1;
    tick(DR + 10);
    peek(2'h0);
    supply_low <= 1'b0;
    ce <= 1'b0;
    pon();
    peek(2'h0);
    ce <= 1'b1;
    pon();
    run_to(6, n);
    for (int g = 0; g < 2; g++) begin
      cfg(32'h4 | (32'(g) << 4));
      osc_run <= 1'b0;
      sleep <= 1'b1;
      tick(1);
      sleep <= 1'b0;
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
      tick(12);
      peek(2'h1);
      osc_run <= 1'b1;
      n = 0;
      @(negedge clk);
      while (!(vec_valid || resume) && n < 40) begin
        @(negedge clk);
        n++;
      end
      chk("wake", {30'h0, g[0], !g[0]}, {30'h0, vec_valid, resume});
      chk("halt", 32'h0, {31'h0, core_halt});
      @(negedge clk);
      if (g == 1)
        chk("vector", 32'h4, {19'h0, vec_addr});
      @(posedge clk);
    end
    close_out();
  end
endmodule

bind reset_timeout_sequencer reset_timeout_sequencer_assertions chk_i (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN),
  .POWER_ON_IN(POWER_ON_IN), .MASTER_CLEAR_B_IN(MASTER_CLEAR_B_IN),
  .CORE_RESET_OUT(CORE_RESET_OUT), .CORE_HALT_OUT(CORE_HALT_OUT),
  .VECTOR_VALID_OUT(VECTOR_VALID_OUT), .VECTOR_ADDR_OUT(VECTOR_ADDR_OUT),
  .RESUME_OUT(RESUME_OUT), .AXI_AWVALID_IN(AXI_AWVALID_IN),
  .AXI_AWREADY_OUT(AXI_AWREADY_OUT), .AXI_WVALID_IN(AXI_WVALID_IN),
  .AXI_WREADY_OUT(AXI_WREADY_OUT), .AXI_BVALID_OUT(AXI_BVALID_OUT),
  .AXI_BREADY_IN(AXI_BREADY_IN), .AXI_ARVALID_IN(AXI_ARVALID_IN),
  .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RVALID_OUT(AXI_RVALID_OUT));
`default_nettype wire
